/* scpr_readout.sv */
`timescale 1ns/1ns
`default_nettype none
`include "scpr_regs.svh"


module scpr_readout
  import scpr_pkg::*;
(
  input  wire logic                    i_clock,
  input  wire logic                    i_rstn,
  input  wire logic                    i_fpga_config_clock,
  input  wire logic                    i_chip_select_n,
  input  wire logic                    i_clear_n_out_enable,
  input  wire logic                    i_serial_program_select_n,
  input  wire logic                    i_page_enable,
  input  wire logic [`SCPR_PAGE_W-1:0] i_page_choice,
  input  wire logic                    i_prog_write,
  input  wire logic                    i_prog_data,
  output var  logic                    o_data,
  output var  logic                    o_data_oe,
  output var  logic                    o_cascade_enable_out,
  output var  logic                    o_ready_oe,
  output var  logic                    o_standby,
  output var  logic                    o_program_mode
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [1:0] page_sync1;
  logic [1:0] page_sync2;
  logic       prog_sync1;
  logic       prog_sync2;
  logic       clk_d;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      // Idle pin levels, so no false link clock edge follows reset
      sync1      <= 6'h1c;
      sync2      <= 6'h1c;
      page_sync1 <= 2'h0;
      page_sync2 <= 2'h0;
      prog_sync1 <= 1'b0;
      prog_sync2 <= 1'b0;
      clk_d      <= 1'b0;
    end else begin
      sync1 <= {i_fpga_config_clock, i_chip_select_n, i_clear_n_out_enable,
                i_serial_program_select_n, i_page_enable, i_prog_write};
      sync2      <= sync1;
      page_sync1 <= i_page_choice;
      page_sync2 <= page_sync1;
      prog_sync1 <= i_prog_data;
      prog_sync2 <= prog_sync1;
      clk_d      <= sync2[5];
    end
  end

  logic s_clk;
  logic s_cs_n;
  logic s_clr_n;
  logic s_ser_n;
  logic s_page_en;
  logic s_pwrite;
  logic s_pdata;
  logic clk_rise;
  assign s_clk     = sync2[5];
  assign s_cs_n    = sync2[4];
  assign s_clr_n   = sync2[3];
  assign s_ser_n   = sync2[2];
  assign s_page_en = sync2[1];
  assign s_pwrite  = sync2[0];
  assign s_pdata   = prog_sync2;
  assign clk_rise  = s_clk & ~clk_d;

  // ----------------------------------------
  // Address helpers
  // ----------------------------------------
  function automatic logic [`SCPR_ADDR_W-1:0] start_addr(
    input logic en, input logic [`SCPR_PAGE_W-1:0] pg);
    start_addr = en ? {pg, {`SCPR_PAGE_BITS_W{1'b0}}}
                    : `SCPR_ADDR_ZERO;
  endfunction : start_addr

  function automatic logic [`SCPR_ADDR_W-1:0] top_addr(
    input logic en, input logic [`SCPR_PAGE_W-1:0] pg);
    top_addr = en ? {pg, `SCPR_PAGE_TOP} : `SCPR_ADDR_TOP;
  endfunction : top_addr

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  scpr_state_type                state;
  scpr_state_type                next_state;
  logic [`SCPR_ADDR_W-1:0]       addr;
  logic [`SCPR_ADDR_W-1:0]       next_addr;
  logic [`SCPR_POR_W-1:0]        por_count;
  logic [`SCPR_POR_W-1:0]        next_por_count;
  logic                          next_data_oe;
  logic                          next_ceo;
  logic                          next_ready_oe;
  logic                          next_standby;
  logic                          next_program_mode;
  logic                          rdata;
  logic                          mem_write;

  assign mem_write = (state == scpr_st_program) & s_pwrite & clk_rise;

  always_comb begin
    next_state        = state;
    next_addr         = addr;
    next_por_count    = por_count;
    next_data_oe      = 1'b0;
    next_ceo          = 1'b1;
    next_ready_oe     = 1'b0;
    next_standby      = 1'b0;
    next_program_mode = 1'b0;
    case (state)
      scpr_st_por: begin
        next_ready_oe = 1'b1;
        next_addr     = start_addr(s_page_en, page_sync2);
        if (por_count == `SCPR_POR_W'(`SCPR_POR_CYCLES - 1)) begin
          next_state    = scpr_st_stream;
          next_ready_oe = 1'b0;
        end else begin
          next_por_count = por_count + `SCPR_POR_W'(1);
        end
      end
      scpr_st_stream, scpr_st_done: begin
        next_standby = s_cs_n;
        if (!s_ser_n) begin
          next_state        = scpr_st_program;
          next_addr         = `SCPR_ADDR_ZERO;
          next_program_mode = 1'b1;
        end else if (!s_clr_n) begin
          next_state = scpr_st_stream;
          next_addr  = start_addr(s_page_en, page_sync2);
        end else if (state == scpr_st_done) begin
          next_ceo = s_cs_n;
        end else if (!s_cs_n) begin
          next_data_oe = 1'b1;
          if (clk_rise) begin
            if (addr == top_addr(s_page_en, page_sync2)) begin
              next_state   = scpr_st_done;
              next_ceo     = 1'b0;
              next_data_oe = 1'b0;
            end else begin
              next_addr = addr + `SCPR_ADDR_W'(1);
            end
          end
        end
        if (s_cs_n) begin
          next_data_oe = 1'b0;
        end
      end
      scpr_st_program: begin
        next_program_mode = 1'b1;
        if (clk_rise) begin
          next_addr = addr + `SCPR_ADDR_W'(1);
        end
        if (s_ser_n) begin
          next_state = scpr_st_stream;
          next_addr  = start_addr(s_page_en, page_sync2);
        end
      end
      default: next_state = scpr_st_por;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state                <= scpr_st_por;
      addr                 <= `SCPR_ADDR_ZERO;
      por_count            <= '0;
      o_data_oe            <= 1'b0;
      o_cascade_enable_out <= 1'b1;
      o_ready_oe           <= 1'b1;
      o_standby            <= 1'b0;
      o_program_mode       <= 1'b0;
      o_data               <= 1'b0;
    end else begin
      state                <= next_state;
      addr                 <= next_addr;
      por_count            <= next_por_count;
      o_data_oe            <= next_data_oe;
      o_cascade_enable_out <= next_ceo;
      o_ready_oe           <= next_ready_oe;
      o_standby            <= next_standby;
      o_program_mode       <= next_program_mode;
      o_data               <= rdata;
    end
  end

  // ----------------------------------------
  // Bit storage
  // ----------------------------------------
  scpr_bit_memory u_mem (
    .i_clock (i_clock),
    .i_addr  (addr),
    .i_write (mem_write),
    .i_wdata (s_pdata),
    .o_rdata (rdata)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_clear_releases: assert property (
    !s_clr_n && s_ser_n |=> !o_data_oe)
    else $error("data driven while cleared");
  a_standby_float: assert property (
    o_standby |-> !o_data_oe)
    else $error("data driven in standby");
  a_cs_freezes: assert property (
    state == scpr_st_stream && s_cs_n && s_clr_n && s_ser_n
      |=> $stable(addr))
    else $error("counter moved with chip select high");
  a_done_ceo_low: assert property (
    state == scpr_st_done && !s_cs_n && s_clr_n && s_ser_n
      |=> !o_cascade_enable_out && !o_data_oe)
    else $error("cascade not low after last bit");
  a_step_one: assert property (
    state == scpr_st_stream && !s_cs_n && s_clr_n && s_ser_n && clk_rise
      && addr != top_addr(s_page_en, page_sync2)
      |=> addr == $past(addr) + `SCPR_ADDR_W'(1))
    else $error("address did not step by one");
  a_clear_start: assert property (
    state != scpr_st_por && state != scpr_st_program && s_ser_n
      && !s_clr_n |=> addr == start_addr($past(s_page_en),
                                         $past(page_sync2)))
    else $error("clear did not restart address");
  a_ready_release: assert property (
    state == scpr_st_stream |-> !o_ready_oe)
    else $error("ready held after power-on");
  a_prog_entry: assert property (
    state == scpr_st_stream && !s_ser_n |=> o_program_mode)
    else $error("program mode not entered");
  a_standby_set: assert property (
    state == scpr_st_stream && s_cs_n && s_ser_n |=> o_standby)
    else $error("standby not flagged");

  c_reach_done:  cover property (state == scpr_st_done);
  c_stream_bit:  cover property (o_data_oe && clk_rise);
  c_prog_mode:   cover property (o_program_mode);
  c_standby:     cover property (o_standby);
endmodule : scpr_readout
`default_nettype wire

/* scpr_regs.svh */
`ifndef SCPR_REGS_SVH
`define SCPR_REGS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define SCPR_ADDR_W       25
`define SCPR_PAGE_W       2
`define SCPR_PAGE_BITS_W  23
`define SCPR_ADDR_ZERO    25'h0000000
`define SCPR_ADDR_TOP     25'h1ffffff
`define SCPR_PAGE_TOP     23'h7fffff

// ----------------------------------------
// Power-on reset hold, in ns and cycles
// ----------------------------------------
`define SCPR_CLK_NS       10
`define SCPR_POR_NS       200
`define SCPR_POR_CYCLES   ((`SCPR_POR_NS + `SCPR_CLK_NS - 1) / `SCPR_CLK_NS)
`define SCPR_POR_W        5

`endif

/* scpr_pkg.sv */
package scpr_pkg;
  typedef enum logic [1:0] {
    scpr_st_por,
    scpr_st_stream,
    scpr_st_done,
    scpr_st_program
  } scpr_state_type;
endpackage : scpr_pkg

/* scpr_bit_memory.sv */
`timescale 1ns/1ns
`default_nettype none
`include "scpr_regs.svh"

module scpr_bit_memory (
  input  wire logic                    i_clock,
  input  wire logic [`SCPR_ADDR_W-1:0] i_addr,
  input  wire logic                    i_write,
  input  wire logic                    i_wdata,
  output var  logic                    o_rdata
);
  // Array contents undefined until programmed; no reset on storage
  logic mem [0:(1<<`SCPR_ADDR_W)-1];

  always_ff @(posedge i_clock) begin
    if (i_write) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule : scpr_bit_memory
`default_nettype wire

/* scpr_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module scpr_host_model (
  input  wire logic i_clock,
  input  wire logic i_data,
  output var  logic o_link_clock,
  output var  logic o_prog_data
);
  // ----------------------------------------
  // Link clock, stands still between frames
  // ----------------------------------------
  initial begin
    o_link_clock = 1'b0;
    o_prog_data  = 1'b0;
  end

  // Host samples just before its rise, so bit k is read before clock k
  task automatic shift(input int n, input logic [15:0] wbits,
                       output logic [15:0] rbits);
    rbits = 16'h0000;
    for (int i = 0; i < n; i++) begin
      o_prog_data = wbits[i];
      repeat (8) @(posedge i_clock);
      #1 rbits[i] = i_data;
      o_link_clock = 1'b1;
      repeat (8) @(posedge i_clock);
      #1 o_link_clock = 1'b0;
    end
  endtask : shift
endmodule : scpr_host_model
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clock, rstn, cs_n, clear_n, ser_n, page_en, prog_write;
  logic [1:0]  page;
  logic [15:0] rd;
  wire logic   link_clk, prog_data, data, data_oe, cascade_enable_out, ready_oe;
  wire logic   standby, prog_mode, din, next_cs_n;
  int          errors  = 0;
  int          checked = 0;
  localparam logic [15:0] pattern = 16'h0b6d;

  // Pull-up holds the line once the device lets go
  assign din = data_oe ? data : 1'b1;
  // Chip select of a following device in the chain
  assign next_cs_n = cascade_enable_out;

  scpr_readout u_dut (
    .i_clock(clock), .i_rstn(rstn), .i_fpga_config_clock(link_clk),
    .i_chip_select_n(cs_n), .i_clear_n_out_enable(clear_n),
    .i_serial_program_select_n(ser_n), .i_page_enable(page_en),
    .i_page_choice(page), .i_prog_write(prog_write),
    .i_prog_data(prog_data), .o_data(data), .o_data_oe(data_oe),
    .o_cascade_enable_out(cascade_enable_out), .o_ready_oe(ready_oe),
    .o_standby(standby), .o_program_mode(prog_mode)
  );

  scpr_host_model u_host (
    .i_clock(clock), .i_data(din),
    .o_link_clock(link_clk), .o_prog_data(prog_data)
  );

  // ----------------------------------------
  // Clock, tasks and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic cmp_flag(input logic exp, input logic got, input string s);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %s", $time, s);
    end
  endtask : cmp_flag

  task automatic cmp_bits(input logic [15:0] exp, input logic [15:0] got,
                          input int n);
    logic [15:0] m;
    m = 16'hffff >> (16 - n);
    checked++;
    if ((got & m) !== (exp & m)) begin
      errors++;
      $display("ERROR %0t stream %h expected %h", $time, got & m, exp & m);
    end
  endtask : cmp_bits

  task automatic final_report;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  // Long runs are a hang, not a slow test
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    final_report();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    cs_n = 1'b1;
    clear_n = 1'b1;
    ser_n = 1'b1;
    page_en = 1'b0;
    page = 2'h0;
    prog_write = 1'b0;
    repeat (6) @(posedge clock);
    #1 rstn = 1'b1;
    cyc(2);
    cmp_flag(1'b1, ready_oe, "ready held");
    for (int i = 0; i < 40 && ready_oe === 1'b1; i++) begin
      cyc(1);
    end
    cmp_flag(1'b0, ready_oe, "ready release");
    // Standby flag lags the end of power-on by one edge
    cyc(2);
    cmp_flag(1'b1, standby, "standby");
    cmp_flag(1'b0, data_oe, "standby float");
    cmp_flag(1'b1, next_cs_n, "next device idle");
    $display("test power_on done");
    ser_n = 1'b0;
    prog_write = 1'b1;
    cyc(4);
    cmp_flag(1'b1, prog_mode, "program mode");
    u_host.shift(12, pattern, rd);
    ser_n = 1'b1;
    prog_write = 1'b0;
    clear_n = 1'b0;
    cyc(4);
    cmp_flag(1'b0, prog_mode, "program exit");
    cmp_flag(1'b0, data_oe, "clear float");
    $display("test program done");
    clear_n = 1'b1;
    cs_n = 1'b0;
    cyc(4);
    cmp_flag(1'b0, standby, "active");
    u_host.shift(8, 16'h0000, rd);
    cmp_bits(pattern, rd, 8);
    cmp_flag(1'b1, data_oe, "driving");
    $display("test stream done");
    cs_n = 1'b1;
    cyc(4);
    u_host.shift(3, 16'h0000, rd);
    cmp_flag(1'b0, data_oe, "deselected float");
    cmp_bits(16'hffff, rd, 3);
    cs_n = 1'b0;
    cyc(4);
    u_host.shift(4, 16'h0000, rd);
    cmp_bits(pattern >> 8, rd, 4);
    clear_n = 1'b0;
    page_en = 1'b1;
    page = 2'h0;
    cyc(4);
    clear_n = 1'b1;
    cyc(4);
    u_host.shift(4, 16'h0000, rd);
    cmp_bits(pattern, rd, 4);
    cmp_flag(1'b1, cascade_enable_out, "cascade idle");
    $display("test hold_clear done");
    final_report();
  end
endmodule : testbench
`default_nettype wire
